// ==== logic/angle_sensor_chain_readout.sv ====
`timescale 1ns/1ps
module angle_sensor_chain_readout (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic chain_clk,
  input wire logic chain_enable_n,
  input wire logic [1:0] output_style_pin,
  input wire logic [1:0] chain_mode_pin,
  input wire logic [1:0] power_save_select,
  input wire logic [1:0] bandwidth_select,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] sine_pos,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] sine_neg,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] cosine_pos,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] cosine_neg,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] mid_supply_reference,
  input wire logic [sensor_chain_pkg::SIG_W-1:0] gain_level,
  input wire logic amplitude_ok,
  output logic [sensor_chain_pkg::SIG_W-1:0] bus_line_a,
  output logic bus_line_a_oe,
  output logic [sensor_chain_pkg::SIG_W-1:0] bus_line_b,
  output logic bus_line_b_oe,
  output logic [sensor_chain_pkg::SIG_W-1:0] ref_port,
  output logic ref_port_oe,
  output logic [sensor_chain_pkg::SIG_W-1:0] fourth_signal_port,
  output logic fourth_signal_port_oe,
  output logic [sensor_chain_pkg::SIG_W-1:0] gain_pin,
  output logic gain_pin_oe,
  output logic amplitude_fault_n,
  output logic amplitude_fault_n_oe,
  output logic next_stage_enable_n,
  output logic hall_power_on,
  output logic [8:0] max_rotary_divisor,
  output logic [13:0] cutoff_hz,
  output logic [4:0] integration_scale
);
  import sensor_chain_pkg::*;

  // Link side: edge counters on the chain clock, cleared while disabled
  logic [2:0] rise_bin;
  logic [2:0] rise_gray;
  logic [2:0] fall_bin;
  logic [2:0] fall_gray;

  always_ff @(posedge chain_clk or posedge chain_enable_n) begin
    if (chain_enable_n) begin
      rise_bin <= 3'h0;
      rise_gray <= 3'h0;
    end else if (rise_bin != EDGE_SATURATE) begin
      // Saturating so stray edges after hand-over never wrap back
      rise_bin <= rise_bin + 3'h1;
      rise_gray <= bin2gray(rise_bin + 3'h1);
    end
  end

  always_ff @(negedge chain_clk or posedge chain_enable_n) begin
    if (chain_enable_n) begin
      fall_bin <= 3'h0;
      fall_gray <= 3'h0;
    end else if (fall_bin != EDGE_SATURATE) begin
      fall_bin <= fall_bin + 3'h1;
      fall_gray <= bin2gray(fall_bin + 3'h1);
    end
  end

  logic enable_n_sync;
  logic [7:0] pins_sync;
  logic [2:0] rise_gray_sync;
  logic [2:0] fall_gray_sync;

  sync2 #(.W(1), .INIT(1'b1)) u_sync_enable (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(chain_enable_n),
    .q(enable_n_sync)
  );

  sync2 #(.W(8), .INIT(8'h00)) u_sync_pins (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({output_style_pin, chain_mode_pin, power_save_select, bandwidth_select}),
    .q(pins_sync)
  );

  sync2 #(.W(6), .INIT(6'h00)) u_sync_edges (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({rise_gray, fall_gray}),
    .q({rise_gray_sync, fall_gray_sync})
  );

  chain_state_t state;
  chain_state_t next_state;
  logic [POWER_CNT_W-1:0] pwr_cnt;
  logic [2:0] rise_base;
  logic [2:0] fall_base;
  logic [2:0] rise_delta;
  logic [2:0] fall_delta;
  logic diff_mode;
  logic chain_mode;
  logic [1:0] power_mode;
  logic [1:0] speed_mode;
  logic power_done;

  assign rise_delta = gray2bin(rise_gray_sync) - rise_base;
  assign fall_delta = gray2bin(fall_gray_sync) - fall_base;
  assign power_done = pwr_cnt == POWER_CNT_W'(POWER_ON_CYCLES - 1);

  always_comb begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (!enable_n_sync) begin
          next_state = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (power_done) begin
          next_state = chain_mode ? ST_WAIT_EDGE1 : ST_SINGLE;
        end
      end
      ST_WAIT_EDGE1: begin
        if (rise_delta >= EDGE_FIRST) begin
          next_state = ST_PHASE1;
        end
      end
      ST_PHASE1: begin
        if (rise_delta >= EDGE_SECOND) begin
          next_state = ST_PHASE2;
        end
      end
      ST_PHASE2: begin
        if (fall_delta >= EDGE_SECOND) begin
          next_state = ST_HANDED;
        end
      end
      default: begin
        next_state = state;
      end
    endcase
    if (enable_n_sync) begin
      next_state = ST_STANDBY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || state != ST_POWER_UP) begin
      pwr_cnt <= '0;
    end else if (!power_done) begin
      pwr_cnt <= pwr_cnt + 1'b1;
    end
  end

  // Edges seen during power-up are taken as the base and so ignored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rise_base <= 3'h0;
      fall_base <= 3'h0;
    end else if (state == ST_POWER_UP) begin
      rise_base <= gray2bin(rise_gray_sync);
      fall_base <= gray2bin(fall_gray_sync);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diff_mode <= 1'b0;
      chain_mode <= 1'b0;
      power_mode <= PIN_HIGH;
      speed_mode <= PIN_HIGH;
    end else if (state == ST_STANDBY && !enable_n_sync) begin
      diff_mode <= pins_sync[7:6] == PIN_HIGH;
      chain_mode <= pins_sync[5:4] == PIN_HIGH;
      power_mode <= pins_sync[3:2];
      speed_mode <= pins_sync[1:0];
    end
  end

  hall_power_gate u_hall_gate (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(state != ST_STANDBY && state != ST_POWER_UP),
    .power_mode(power_mode),
    .hall_power_on(hall_power_on)
  );

  logic [4:0] power_div;
  logic [4:0] speed_div;

  always_comb begin
    if (power_mode == PIN_LOW) begin
      power_div = 5'(REDUCED_POWER_DIV);
    end else if (power_mode == PIN_OPEN) begin
      power_div = 5'(ECO_POWER_DIV);
    end else begin
      power_div = 5'(FULL_POWER_DIV);
    end
    if (speed_mode == PIN_LOW) begin
      speed_div = 5'(HALF_SPEED_DIV);
    end else if (speed_mode == PIN_OPEN) begin
      speed_div = 5'(MIN_SPEED_DIV);
    end else begin
      speed_div = 5'(FULL_SPEED_DIV);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      max_rotary_divisor <= 9'(FULL_POWER_DIV * FULL_SPEED_DIV);
      cutoff_hz <= 14'(CUTOFF_FULL_HZ);
      integration_scale <= 5'(FULL_SPEED_DIV);
    end else begin
      // Widen before multiplying: 6 x 20 does not fit in five bits
      max_rotary_divisor <= 9'(power_div) * 9'(speed_div);
      integration_scale <= speed_div;
      if (speed_mode == PIN_LOW) begin
        cutoff_hz <= 14'(CUTOFF_HALF_HZ);
      end else if (speed_mode == PIN_OPEN) begin
        cutoff_hz <= 14'(CUTOFF_MIN_HZ);
      end else begin
        cutoff_hz <= 14'(CUTOFF_FULL_HZ);
      end
    end
  end

  // Async clear so a disable floats the bus even with the core clock stopped
  always_ff @(posedge core_clk or posedge chain_enable_n) begin
    if (chain_enable_n) begin
      bus_line_a_oe <= 1'b0;
      bus_line_b_oe <= 1'b0;
      ref_port_oe <= 1'b0;
      fourth_signal_port_oe <= 1'b0;
      gain_pin_oe <= 1'b0;
      amplitude_fault_n_oe <= 1'b0;
      next_stage_enable_n <= 1'b1;
    end else if (!rst_n) begin
      bus_line_a_oe <= 1'b0;
      bus_line_b_oe <= 1'b0;
      ref_port_oe <= 1'b0;
      fourth_signal_port_oe <= 1'b0;
      gain_pin_oe <= 1'b0;
      amplitude_fault_n_oe <= 1'b0;
      next_stage_enable_n <= 1'b1;
    end else begin
      bus_line_a_oe <= state inside {ST_PHASE1, ST_PHASE2, ST_SINGLE};
      bus_line_b_oe <= state inside {ST_PHASE1, ST_PHASE2, ST_SINGLE};
      ref_port_oe <= state == ST_SINGLE;
      fourth_signal_port_oe <= state == ST_SINGLE;
      gain_pin_oe <= state inside {ST_PHASE1, ST_PHASE2, ST_SINGLE};
      amplitude_fault_n_oe <= !amplitude_ok && state inside {ST_PHASE1, ST_PHASE2, ST_SINGLE};
      next_stage_enable_n <= state != ST_HANDED;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_line_a <= '0;
      bus_line_b <= '0;
      ref_port <= '0;
      fourth_signal_port <= '0;
      gain_pin <= '0;
      amplitude_fault_n <= 1'b0;
    end else begin
      gain_pin <= gain_level;
      amplitude_fault_n <= 1'b0;
      ref_port <= diff_mode ? sine_neg : mid_supply_reference;
      fourth_signal_port <= diff_mode ? cosine_neg : gain_level;
      if (state == ST_PHASE2 && diff_mode) begin
        bus_line_a <= sine_neg;
        bus_line_b <= cosine_neg;
      end else if (state == ST_PHASE2) begin
        bus_line_a <= mid_supply_reference;
        bus_line_b <= gain_level;
      end else begin
        bus_line_a <= sine_pos;
        bus_line_b <= cosine_pos;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_first_pair;
    bus_line_a_oe && bus_line_a == $past(sine_pos) && bus_line_b == $past(cosine_pos);
  endsequence

  sequence s_handed;
    state == ST_HANDED ##1 (!next_stage_enable_n && !bus_line_a_oe && !bus_line_b_oe);
  endsequence

  a_first_pair: assert property (state == ST_PHASE1 && !chain_enable_n
    |=> chain_enable_n or s_first_pair)
    else $error("first pair not on bus");
  a_second_single: assert property (state == ST_PHASE2 && !diff_mode && !chain_enable_n
    |=> bus_line_a == $past(mid_supply_reference) && bus_line_b == $past(gain_level))
    else $error("single-ended second pair wrong");
  a_second_diff: assert property (state == ST_PHASE2 && diff_mode
    |=> bus_line_a == $past(sine_neg) && bus_line_b == $past(cosine_neg))
    else $error("differential second pair wrong");
  a_hiz_before_edge: assert property (state == ST_WAIT_EDGE1 |=> !bus_line_a_oe && !bus_line_b_oe)
    else $error("bus driven before first edge");
  a_mode_hold: assert property (state != ST_STANDBY && $past(state) != ST_STANDBY
    |-> $stable(diff_mode) && $stable(chain_mode) && $stable(power_mode))
    else $error("mode changed while active");
  a_power_wait: assert property (state == ST_POWER_UP && !power_done
    |=> state inside {ST_POWER_UP, ST_STANDBY})
    else $error("left power-up early");
  a_power_count: assert property ($rose(state == ST_WAIT_EDGE1)
    |-> $past(pwr_cnt) == POWER_CNT_W'(POWER_ON_CYCLES - 1))
    else $error("power-on delay not observed");
  a_handover: assert property (state == ST_PHASE2 && fall_delta >= EDGE_SECOND && !enable_n_sync
    |=> state == ST_HANDED)
    else $error("handover sequencing");
  a_handover_low: assert property (state == ST_PHASE2 && fall_delta >= EDGE_SECOND
    && !enable_n_sync ##1 !chain_enable_n |-> s_handed)
    else $error("next stage not enabled at handover");
  a_single_driver: assert property (!next_stage_enable_n |-> !bus_line_a_oe && !bus_line_b_oe)
    else $error("bus driven after handover");
  a_async_release: assert property (chain_enable_n
    |-> next_stage_enable_n && !bus_line_a_oe && !gain_pin_oe)
    else $error("disable did not float outputs");
  a_ignore_after: assert property (state == ST_HANDED && !enable_n_sync |=> state == ST_HANDED)
    else $error("clock activity after handover acted on");
  a_divisor_product: assert property ($stable(power_mode) && $stable(speed_mode)
    |=> max_rotary_divisor == 9'($past(power_div)) * 9'($past(speed_div)))
    else $error("rotary divisor not product");
endmodule

// ==== logic/hall_power_gate.sv ====
`timescale 1ns/1ps
module hall_power_gate (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] power_mode,
  output logic hall_power_on
);
  import sensor_chain_pkg::*;

  logic [HALL_CNT_W-1:0] cnt;
  logic [HALL_CNT_W-1:0] off_len;
  logic running;

  always_comb begin
    if (power_mode == PIN_LOW) begin
      off_len = HALL_CNT_W'(SENSOR_IDLE_REDUCED_CYCLES);
    end else if (power_mode == PIN_OPEN) begin
      off_len = HALL_CNT_W'(SENSOR_IDLE_ECO_CYCLES);
    end else begin
      off_len = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      cnt <= '0;
      hall_power_on <= 1'b0;
      running <= 1'b0;
    end else if (!running) begin
      // Start with a measurement so the first sample is not delayed
      running <= 1'b1;
      hall_power_on <= 1'b1;
      cnt <= '0;
    end else if (off_len == '0) begin
      hall_power_on <= 1'b1;
      cnt <= '0;
    end else if (hall_power_on) begin
      if (cnt == HALL_CNT_W'(SENSOR_ACTIVE_CYCLES - 1)) begin
        hall_power_on <= 1'b0;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end else if (cnt == off_len - 1'b1) begin
      hall_power_on <= 1'b1;
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_active_end: assert property (enable && running && hall_power_on && off_len != '0
    && cnt == HALL_CNT_W'(SENSOR_ACTIVE_CYCLES - 1) |=> !hall_power_on)
    else $error("hall active time wrong");
  a_active_bound: assert property (enable && running && hall_power_on && off_len != '0
    |-> cnt < HALL_CNT_W'(SENSOR_ACTIVE_CYCLES))
    else $error("hall active phase too long");
  a_idle_hold: assert property (enable && $past(enable) && running && !hall_power_on
    && $stable(power_mode) && cnt < off_len - 1'b1 |=> !hall_power_on)
    else $error("hall idle phase cut short");
  a_full_on: assert property (enable && running && off_len == '0 |=> enable -> hall_power_on)
    else $error("hall sensors not continuous");
endmodule

// ==== logic/sensor_chain_pkg.sv ====
package sensor_chain_pkg;
  localparam int SIG_W = 12;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_OPEN = 2'h2;
  localparam int CORE_CLK_PERIOD_NS = 100;
  localparam int POWER_ON_DELAY_NS = 50000;
  localparam int POWER_ON_CYCLES = (POWER_ON_DELAY_NS + CORE_CLK_PERIOD_NS - 1)
                                   / CORE_CLK_PERIOD_NS;
  localparam int POWER_CNT_W = 10;
  localparam int SENSOR_ACTIVE_NS = 10000;
  localparam int SENSOR_ACTIVE_CYCLES = (SENSOR_ACTIVE_NS + CORE_CLK_PERIOD_NS - 1)
                                        / CORE_CLK_PERIOD_NS;
  localparam int FULL_POWER_DIV = 1;
  localparam int REDUCED_POWER_DIV = 6;
  localparam int ECO_POWER_DIV = 18;
  localparam int SENSOR_IDLE_REDUCED_CYCLES = SENSOR_ACTIVE_CYCLES * (REDUCED_POWER_DIV - 1);
  localparam int SENSOR_IDLE_ECO_CYCLES = SENSOR_ACTIVE_CYCLES * (ECO_POWER_DIV - 1);
  localparam int HALL_CNT_W = 12;
  localparam int FULL_SPEED_DIV = 1;
  localparam int HALF_SPEED_DIV = 2;
  localparam int MIN_SPEED_DIV = 20;
  localparam int CUTOFF_FULL_HZ = 10000;
  localparam int CUTOFF_HALF_HZ = 5000;
  localparam int CUTOFF_MIN_HZ = 500;
  localparam logic [2:0] EDGE_FIRST = 3'h1;
  localparam logic [2:0] EDGE_SECOND = 3'h2;
  localparam logic [2:0] EDGE_SATURATE = 3'h7;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_POWER_UP,
    ST_WAIT_EDGE1,
    ST_PHASE1,
    ST_PHASE2,
    ST_HANDED,
    ST_SINGLE
  } chain_state_t;

  function automatic logic [2:0] bin2gray(input logic [2:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [2:0] gray2bin(input logic [2:0] g);
    logic [2:0] b;
    b[2] = g[2];
    b[1] = g[1] ^ g[2];
    b[0] = g[0] ^ g[1] ^ g[2];
    return b;
  endfunction
endpackage

// ==== logic/sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== sim/chain_host.sv ====
`timescale 1ns/1ps
module chain_host (
  output logic chain_clk,
  output logic chain_enable_n
);
  initial begin
    chain_clk = 1'b0;
    chain_enable_n = 1'b1;
  end
  // Clock parked low first so activation never sees a stray edge
  task automatic start_chain();
    chain_clk = 1'b0;
    #20;
    chain_enable_n = 1'b0;
  endtask
  task automatic rise();
    chain_clk = 1'b1;
  endtask
  task automatic fall();
    chain_clk = 1'b0;
  endtask
  // Narrow pulse at half the 6 ns link period
  task automatic pulse();
    rise();
    #3;
    fall();
  endtask
  // Margin of 1000 ns on top of the power-up delay, waited once per chain and abort run
  task automatic wait_power_on();
    #(sensor_chain_pkg::POWER_ON_DELAY_NS + 1000);
  endtask
  task automatic stop_chain();
    chain_enable_n = 1'b1;
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import sensor_chain_pkg::*;
  logic core_clk, rst_n, chain_clk, chain_enable_n, amplitude_ok, fault_line;
  logic [1:0] output_style_pin, chain_mode_pin, power_save_select, bandwidth_select;
  logic [SIG_W-1:0] sine_pos, sine_neg, cosine_pos, cosine_neg, mid_supply_reference, gain_level;
  logic [SIG_W-1:0] bus_line_a, bus_line_b, ref_port, fourth_signal_port, gain_pin;
  logic bus_line_a_oe, bus_line_b_oe, ref_port_oe, fourth_signal_port_oe, gain_pin_oe;
  logic amplitude_fault_n, amplitude_fault_n_oe, next_stage_enable_n, hall_power_on;
  logic [8:0] max_rotary_divisor;
  logic [13:0] cutoff_hz;
  logic [4:0] integration_scale;
  int fails = 0;
  int compares = 0;

  // Open-drain fault line with its pull-up
  assign fault_line = amplitude_fault_n_oe ? amplitude_fault_n : 1'b1;

  chain_host chain_host_i (.chain_clk, .chain_enable_n);

  angle_sensor_chain_readout angle_sensor_chain_readout_i (
    .core_clk, .rst_n, .chain_clk, .chain_enable_n, .output_style_pin, .chain_mode_pin,
    .power_save_select, .bandwidth_select, .sine_pos, .sine_neg, .cosine_pos, .cosine_neg,
    .mid_supply_reference, .gain_level, .amplitude_ok, .bus_line_a, .bus_line_a_oe,
    .bus_line_b, .bus_line_b_oe, .ref_port, .ref_port_oe, .fourth_signal_port,
    .fourth_signal_port_oe, .gain_pin, .gain_pin_oe, .amplitude_fault_n,
    .amplitude_fault_n_oe, .next_stage_enable_n, .hall_power_on, .max_rotary_divisor,
    .cutoff_hz, .integration_scale
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  task automatic set_data(input logic [3:0] s);
    sine_pos = {s, 8'h11};
    sine_neg = {s, 8'h22};
    cosine_pos = {s, 8'h33};
    cosine_neg = {s, 8'h44};
    mid_supply_reference = {s, 8'h55};
    gain_level = {s, 8'h66};
  endtask

  task automatic set_pins(input logic [1:0] st, input logic [1:0] ch, input logic [1:0] pw,
                          input logic [1:0] bw);
    output_style_pin = st;
    chain_mode_pin = ch;
    power_save_select = pw;
    bandwidth_select = bw;
  endtask

  task automatic chain_run(input logic diff);
    set_pins(diff ? PIN_HIGH : PIN_LOW, PIN_HIGH, PIN_HIGH, PIN_HIGH);
    set_data(diff ? 4'h5 : 4'h3);
    chain_host_i.start_chain();
    cycles(100);
    chain_host_i.pulse();
    cycles(10);
    check("early_oe", bus_line_a_oe, 1'b0);
    chain_host_i.wait_power_on();
    cycles(1);
    check("wait_oe", bus_line_b_oe, 1'b0);
    chain_host_i.pulse();
    cycles(6);
    check("p1_oe", {bus_line_a_oe, bus_line_b_oe, gain_pin_oe}, 3'h7);
    check("p1_a", bus_line_a, sine_pos);
    check("p1_b", bus_line_b, cosine_pos);
    check("fault_ok", fault_line, 1'b1);
    amplitude_ok = 1'b0;
    cycles(3);
    check("fault_bad", fault_line, 1'b0);
    amplitude_ok = 1'b1;
    // Mode pins moved after activation must not affect this cycle
    output_style_pin = diff ? PIN_LOW : PIN_HIGH;
    cycles(3);
    chain_host_i.rise();
    cycles(6);
    check("p2_a", bus_line_a, diff ? sine_neg : mid_supply_reference);
    check("p2_b", bus_line_b, diff ? cosine_neg : gain_level);
    check("gain_pin", gain_pin, gain_level);
    chain_host_i.fall();
    cycles(6);
    check("hand_next", next_stage_enable_n, 1'b0);
    check("hand_oe", {bus_line_a_oe, bus_line_b_oe, gain_pin_oe}, 3'h0);
    chain_host_i.pulse();
    cycles(6);
    check("late_oe", bus_line_a_oe, 1'b0);
    check("late_next", next_stage_enable_n, 1'b0);
    chain_host_i.stop_chain();
    #1;
    check("stop_next", next_stage_enable_n, 1'b1);
    cycles(5);
  endtask

  task automatic abort_run();
    set_pins(PIN_LOW, PIN_HIGH, PIN_HIGH, PIN_HIGH);
    set_data(4'h9);
    chain_host_i.start_chain();
    chain_host_i.wait_power_on();
    cycles(1);
    chain_host_i.pulse();
    cycles(6);
    check("abort_on", bus_line_a_oe, 1'b1);
    #20;
    chain_host_i.stop_chain();
    #1;
    check("abort_oe", {bus_line_a_oe, bus_line_b_oe}, 2'h0);
    check("abort_next", next_stage_enable_n, 1'b1);
    cycles(5);
  endtask

  task automatic power_run(input logic [1:0] pw, input logic [1:0] bw, input int pdiv,
                           input int sdiv, input int cut);
    int ones;
    int waited;
    int per;
    ones = 0;
    waited = 0;
    per = SENSOR_ACTIVE_CYCLES * ((pdiv == 1) ? 6 : pdiv);
    set_pins(PIN_LOW, PIN_LOW, pw, bw);
    set_data(4'hc);
    chain_host_i.start_chain();
    cycles(3);
    check("hall_early", hall_power_on, 1'b0);
    while (hall_power_on !== 1'b1 && waited < 700) begin
      cycles(1);
      waited++;
    end
    check("hall_on", hall_power_on, 1'b1);
    check("divisor", max_rotary_divisor, pdiv * sdiv);
    check("cutoff", cutoff_hz, cut);
    check("scale", integration_scale, sdiv);
    check("se_gain", fourth_signal_port, gain_level);
    // Skip the first burst so the window sees only the periodic part
    cycles(200);
    repeat (per) begin
      if (hall_power_on === 1'b1) begin
        ones++;
      end
      cycles(1);
    end
    check("hall_duty", ones, (pdiv == 1) ? per : SENSOR_ACTIVE_CYCLES);
    chain_host_i.stop_chain();
    cycles(5);
  endtask

  initial begin
    rst_n = 1'b0;
    amplitude_ok = 1'b1;
    set_pins(PIN_LOW, PIN_HIGH, PIN_HIGH, PIN_HIGH);
    set_data(4'h1);
    repeat (5) @(posedge core_clk);
    #5;
    rst_n = 1'b1;
    check("rst_next", next_stage_enable_n, 1'b1);
    chain_run(1'b0);
    chain_run(1'b1);
    abort_run();
    power_run(PIN_HIGH, PIN_LOW, 1, 2, CUTOFF_HALF_HZ);
    power_run(PIN_LOW, PIN_OPEN, 6, 20, CUTOFF_MIN_HZ);
    power_run(PIN_OPEN, PIN_HIGH, 18, 1, CUTOFF_FULL_HZ);
    print_verdict();
  end

  initial begin
    #2_000_000;
    fails++;
    print_verdict();
  end
endmodule
